// >>> shared/pwr_pkg.sv
// package for the privileged register write unit
// assumes one core clock and an issue stage that presents one instruction
package pwr_pkg;
    localparam int XLEN_W          = 64;
    localparam int INSN_W          = 32;
    localparam int DEST_W          = 5;
    localparam int IMM_W           = 13;
    localparam int IMM_FLAG_BIT    = 13;
    localparam int DEST_LSB        = 25;
    localparam int PAD_MSB         = 12;
    localparam int PAD_LSB         = 5;
    localparam int TL_W            = 3;
    localparam int GL_W            = 3;
    localparam int WIN_W           = 3;
    localparam int PIL_W           = 4;
    localparam int PST_W           = 13;
    localparam int PST_PRIV_BIT    = 2;
    localparam int TT_W            = 9;
    localparam int TST_W           = 48;
    localparam int TBA_W           = 49;
    localparam int TBA_LSB         = 15;
    localparam int WSTATE_W        = 6;
    localparam logic [PST_W-1:0] PST_RESET = 13'h0004;

    typedef enum logic [DEST_W-1:0] {
        PWR_DST_TPC    = 5'h00,
        PWR_DST_TNPC   = 5'h01,
        PWR_DST_TSTATE = 5'h02,
        PWR_DST_TT     = 5'h03,
        PWR_DST_RSV4   = 5'h04,
        PWR_DST_TBA    = 5'h05,
        PWR_DST_PST    = 5'h06,
        PWR_DST_TL     = 5'h07,
        PWR_DST_PIL    = 5'h08,
        PWR_DST_CWP    = 5'h09,
        PWR_DST_CANSV  = 5'h0A,
        PWR_DST_CANRS  = 5'h0B,
        PWR_DST_CLNWIN = 5'h0C,
        PWR_DST_OTHWIN = 5'h0D,
        PWR_DST_WSTATE = 5'h0E,
        PWR_DST_RSV15  = 5'h0F,
        PWR_DST_GL     = 5'h10
    } pwr_dest_t;

    typedef struct packed {
        logic              valid;
        logic [INSN_W-1:0] insn;
        logic [XLEN_W-1:0] src_one;
        logic [XLEN_W-1:0] src_two;
    } pwr_issue_t;

    typedef struct packed {
        logic priv_fault;
        logic illegal_fault;
        logic done;
    } pwr_result_t;
endpackage : pwr_pkg

// >>> logic/pwr_unit.sv
// privileged state register write: operand xor, target decode, exceptions
// assumes issue presents operands already read; one instruction per cycle
//
// Contract
// - write source one xor operand two or imm
// - destination field selects the target register
// - one trap register copy per level 1..MAX_TL
// - trap copy indexed by current trap level
// - trap level write stores the value clamped to MAX_TL
// - next instruction sees the new value
// - trap level write saturates at limit
// - global level write saturates at limit
// - nonprivileged execution raises privilege fault
// - register form with nonzero pad illegal
// - codes 4, 15, 17-31 illegal
// - trap regs at level zero illegal
// - privilege fault wins over illegal encoding
module pwr_unit
    import pwr_pkg::*;
#(
    parameter int MAX_TL = 6,
    parameter int MAX_GL = 3
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire pwr_issue_t            issue,
    output pwr_result_t                result,
    output logic [XLEN_W-1:0]          trap_pc,
    output logic [XLEN_W-1:0]          trap_npc,
    output logic [TST_W-1:0]           trap_state,
    output logic [TT_W-1:0]            trap_type_code,
    output logic [XLEN_W-1:0]          trap_base,
    output logic [PST_W-1:0]           proc_state,
    output logic [TL_W-1:0]            trap_level,
    output logic [PIL_W-1:0]           irq_level,
    output logic [WIN_W-1:0]           cur_window,
    output logic [WIN_W-1:0]           can_save,
    output logic [WIN_W-1:0]           can_restore,
    output logic [WIN_W-1:0]           clean_win,
    output logic [WIN_W-1:0]           other_win,
    output logic [WSTATE_W-1:0]        win_state,
    output logic [GL_W-1:0]            global_set_level
);
    localparam logic [TL_W-1:0] TL_MAX = TL_W'(MAX_TL);
    localparam logic [GL_W-1:0] GL_MAX = GL_W'(MAX_GL);

    function automatic logic [TL_W-1:0] clamp_tl(input logic [XLEN_W-1:0] v);
        return (v > XLEN_W'(MAX_TL)) ? TL_MAX : v[TL_W-1:0];
    endfunction : clamp_tl

    function automatic logic [GL_W-1:0] clamp_gl(input logic [XLEN_W-1:0] v);
        return (v > XLEN_W'(MAX_GL)) ? GL_MAX : v[GL_W-1:0];
    endfunction : clamp_gl

    // per-level trap copies, level 1..MAX_TL
    logic [XLEN_W-1:0] tpc_q    [1:MAX_TL];
    logic [XLEN_W-1:0] tnpc_q   [1:MAX_TL];
    logic [TST_W-1:0]  tstate_q [1:MAX_TL];
    logic [TT_W-1:0]   tt_q     [1:MAX_TL];
    logic [XLEN_W-1:0] tpc_d    [1:MAX_TL];
    logic [XLEN_W-1:0] tnpc_d   [1:MAX_TL];
    logic [TST_W-1:0]  tstate_d [1:MAX_TL];
    logic [TT_W-1:0]   tt_d     [1:MAX_TL];

    logic [TBA_W-1:0]    tba_q, tba_d;
    logic [PST_W-1:0]    pst_q, pst_d;
    logic [TL_W-1:0]     tl_q, tl_d;
    logic [PIL_W-1:0]    pil_q, pil_d;
    logic [WIN_W-1:0]    cwp_q, cwp_d;
    logic [WIN_W-1:0]    cansv_q, cansv_d;
    logic [WIN_W-1:0]    canrs_q, canrs_d;
    logic [WIN_W-1:0]    clnwin_q, clnwin_d;
    logic [WIN_W-1:0]    othwin_q, othwin_d;
    logic [WSTATE_W-1:0] wstate_q, wstate_d;
    logic [GL_W-1:0]     gl_q, gl_d;
    pwr_result_t         res_q, res_d;

    logic              imm_flag;
    logic [DEST_W-1:0] dest;
    logic [XLEN_W-1:0] operand_two;
    logic [XLEN_W-1:0] wval;
    logic              is_priv;
    logic              pad_bad;
    logic              dest_bad;
    logic              trap_reg_bad;
    logic              priv_fault;
    logic              illegal_fault;
    logic              do_write;

    always_comb begin
        imm_flag    = issue.insn[IMM_FLAG_BIT];
        dest        = issue.insn[DEST_LSB +: DEST_W];
        operand_two = imm_flag
            ? {{(XLEN_W-IMM_W){issue.insn[IMM_W-1]}}, issue.insn[IMM_W-1:0]}
            : issue.src_two;
        wval        = issue.src_one ^ operand_two;
        is_priv     = pst_q[PST_PRIV_BIT];
        pad_bad     = !imm_flag && (issue.insn[PAD_MSB:PAD_LSB] != 8'h00);
        dest_bad    = (dest == PWR_DST_RSV4) || (dest == PWR_DST_RSV15)
                      || (dest > PWR_DST_GL);
        trap_reg_bad = (dest <= PWR_DST_TT) && (tl_q == '0);
        priv_fault  = issue.valid && !is_priv;
        illegal_fault = issue.valid && is_priv
                        && (pad_bad || dest_bad || trap_reg_bad);
        do_write    = issue.valid && !priv_fault && !illegal_fault;
    end

    always_comb begin
        tpc_d    = tpc_q;
        tnpc_d   = tnpc_q;
        tstate_d = tstate_q;
        tt_d     = tt_q;
        tba_d    = tba_q;
        pst_d    = pst_q;
        tl_d     = tl_q;
        pil_d    = pil_q;
        cwp_d    = cwp_q;
        cansv_d  = cansv_q;
        canrs_d  = canrs_q;
        clnwin_d = clnwin_q;
        othwin_d = othwin_q;
        wstate_d = wstate_q;
        gl_d     = gl_q;
        res_d.priv_fault    = priv_fault;
        res_d.illegal_fault = illegal_fault;
        res_d.done          = issue.valid;
        if (do_write) begin
            unique case (dest)
                PWR_DST_TPC:    tpc_d[tl_q]    = wval;
                PWR_DST_TNPC:   tnpc_d[tl_q]   = wval;
                PWR_DST_TSTATE: tstate_d[tl_q] = wval[TST_W-1:0];
                PWR_DST_TT:     tt_d[tl_q]     = wval[TT_W-1:0];
                PWR_DST_TBA:    tba_d    = wval[XLEN_W-1:TBA_LSB];
                PWR_DST_PST:    pst_d    = wval[PST_W-1:0];
                PWR_DST_TL:     tl_d     = clamp_tl(wval);
                PWR_DST_PIL:    pil_d    = wval[PIL_W-1:0];
                PWR_DST_CWP:    cwp_d    = wval[WIN_W-1:0];
                PWR_DST_CANSV:  cansv_d  = wval[WIN_W-1:0];
                PWR_DST_CANRS:  canrs_d  = wval[WIN_W-1:0];
                PWR_DST_CLNWIN: clnwin_d = wval[WIN_W-1:0];
                PWR_DST_OTHWIN: othwin_d = wval[WIN_W-1:0];
                PWR_DST_WSTATE: wstate_d = wval[WSTATE_W-1:0];
                PWR_DST_GL:     gl_d     = clamp_gl(wval);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 1; i <= MAX_TL; i++) begin
                tpc_q[i]    <= '0;
                tnpc_q[i]   <= '0;
                tstate_q[i] <= '0;
                tt_q[i]     <= '0;
            end
            tba_q    <= '0;
            pst_q    <= PST_RESET;
            tl_q     <= TL_MAX;
            pil_q    <= '0;
            cwp_q    <= '0;
            cansv_q  <= '0;
            canrs_q  <= '0;
            clnwin_q <= '0;
            othwin_q <= '0;
            wstate_q <= '0;
            gl_q     <= GL_MAX;
            res_q    <= '0;
        end else begin
            tpc_q    <= tpc_d;
            tnpc_q   <= tnpc_d;
            tstate_q <= tstate_d;
            tt_q     <= tt_d;
            tba_q    <= tba_d;
            pst_q    <= pst_d;
            tl_q     <= tl_d;
            pil_q    <= pil_d;
            cwp_q    <= cwp_d;
            cansv_q  <= cansv_d;
            canrs_q  <= canrs_d;
            clnwin_q <= clnwin_d;
            othwin_q <= othwin_d;
            wstate_q <= wstate_d;
            gl_q     <= gl_d;
            res_q    <= res_d;
        end
    end

    // state visible one edge after the write, before the next issue
    always_comb begin
        result           = res_q;
        trap_pc          = (tl_q == '0) ? '0 : tpc_q[tl_q];
        trap_npc         = (tl_q == '0) ? '0 : tnpc_q[tl_q];
        trap_state       = (tl_q == '0) ? '0 : tstate_q[tl_q];
        trap_type_code   = (tl_q == '0) ? '0 : tt_q[tl_q];
        trap_base        = {tba_q, {TBA_LSB{1'b0}}};
        proc_state       = pst_q;
        trap_level       = tl_q;
        irq_level        = pil_q;
        cur_window       = cwp_q;
        can_save         = cansv_q;
        can_restore      = canrs_q;
        clean_win        = clnwin_q;
        other_win        = othwin_q;
        win_state        = wstate_q;
        global_set_level = gl_q;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_tl_saturate: assert property (do_write && dest == PWR_DST_TL
        |=> trap_level == clamp_tl($past(wval)))
        else $error("trap level write not clamped");
    a_gl_saturate: assert property (do_write && dest == PWR_DST_GL
        |=> global_set_level == clamp_gl($past(wval)))
        else $error("global level write not clamped");
    a_priv_first: assert property (issue.valid && !is_priv
        |=> result.priv_fault && !result.illegal_fault)
        else $error("privilege fault lost priority");
    a_priv_nowrite: assert property (issue.valid && !is_priv
        |=> $stable(proc_state) && $stable(trap_level))
        else $error("write happened without privilege");
    a_pad_illegal: assert property (issue.valid && is_priv && pad_bad
        |=> result.illegal_fault)
        else $error("nonzero pad not flagged");
    a_dest_illegal: assert property (issue.valid && is_priv && dest_bad
        |=> result.illegal_fault)
        else $error("reserved code not flagged");
    a_tl0_illegal: assert property (issue.valid && is_priv
        && dest <= PWR_DST_TT && trap_level == '0 |=> result.illegal_fault)
        else $error("trap reg at level zero not flagged");
    a_fault_nowrite: assert property (illegal_fault
        |=> $stable(trap_level) && $stable(global_set_level)
            && $stable(proc_state))
        else $error("faulting write changed state");
    a_tl_only: assert property (do_write && dest == PWR_DST_TL
        |=> $stable(proc_state) && $stable(global_set_level))
        else $error("trap level write touched other state");
    a_pil_store: assert property (do_write && dest == PWR_DST_PIL
        |=> irq_level == $past(wval[PIL_W-1:0]))
        else $error("xor value not stored");
    a_tpc_index: assert property (do_write && dest == PWR_DST_TPC
        ##1 $stable(trap_level) |-> trap_pc == $past(wval))
        else $error("trap pc copy not indexed by level");

    c_tl_write:  cover property (do_write && dest == PWR_DST_TL);
    c_gl_clamp:  cover property (do_write && dest == PWR_DST_GL
                                 && wval > XLEN_W'(MAX_GL));
    c_priv_flt:  cover property (priv_fault);
    c_tl0_flt:   cover property (illegal_fault && trap_reg_bad);
endmodule : pwr_unit

// >>> testbench/pwr_issue_model.sv
// issue stage model: presents one instruction per call
// assumes the unit samples issue on the rising edge of clk_sys
module pwr_issue_model
    import pwr_pkg::*;
(
    input  wire logic clk_sys,
    output pwr_issue_t issue
);
    timeunit 1ns;
    timeprecision 1ps;
    initial issue = '0;
    // drive at the falling edge; idle slots show inverted stale fields
    task automatic drive(input logic v, input logic [INSN_W-1:0] insn,
                         input logic [XLEN_W-1:0] a,
                         input logic [XLEN_W-1:0] b);
        @(negedge clk_sys);
        issue.valid   = v;
        issue.insn    = v ? insn : ~issue.insn;
        issue.src_one = v ? a : ~issue.src_one;
        issue.src_two = v ? b : ~issue.src_two;
    endtask : drive
endmodule : pwr_issue_model

// >>> testbench/pwr_unit_tb.sv
// bench for the privileged register write unit
// assumes one core clock; results one cycle after each issue
module pwr_unit_tb
    import pwr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk_sys = 1'b0;
    logic              rst_n   = 1'b0;
    pwr_issue_t        issue;
    pwr_result_t       result;
    logic [XLEN_W-1:0] tpc, tnpc, tba;
    logic [TST_W-1:0]  tst;
    logic [TT_W-1:0]   ttc;
    logic [PST_W-1:0]  pst;
    logic [TL_W-1:0]   tl;
    logic [GL_W-1:0]   gl;
    logic [PIL_W-1:0]  pil;
    logic [WIN_W-1:0]  cwp, csv, crs, cln, oth;
    logic [WSTATE_W-1:0] wst;
    logic [104:0]      glob, snap;
    logic [XLEN_W-1:0] a = 64'h5A5A_A5A5_3C3C_C3C1;
    logic [XLEN_W-1:0] b = 64'hFFFF_FFFF_FFFF_FFFF;
    logic [XLEN_W-1:0] v = 64'hA5A5_5A5A_C3C3_3C3E;
    int                num_errors = 0;
    int                n_checks   = 0;
    assign glob = {tba, pst, pil, cwp, csv, crs, cln, oth, wst, gl};
    always #4 clk_sys = ~clk_sys;
    pwr_issue_model mdl (.clk_sys(clk_sys), .issue(issue));
    pwr_unit #(.MAX_TL(6), .MAX_GL(3)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .issue(issue), .result(result),
        .trap_pc(tpc), .trap_npc(tnpc), .trap_state(tst),
        .trap_type_code(ttc), .trap_base(tba), .proc_state(pst),
        .trap_level(tl), .irq_level(pil), .cur_window(cwp),
        .can_save(csv), .can_restore(crs), .clean_win(cln),
        .other_win(oth), .win_state(wst), .global_set_level(gl));
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [INSN_W-1:0] mk(input int c, input logic i,
                                              input logic [12:0] imm);
        mk = {2'h0, c[4:0], 11'h000, i, imm};
    endfunction : mk
    // one instruction then an idle slot, result checked in the idle slot
    task automatic go(input int c, input logic i, input logic [12:0] imm,
                      input logic [XLEN_W-1:0] x, input logic [XLEN_W-1:0] y,
                      input logic pf, input logic il);
        mdl.drive(1'b1, mk(c, i, imm), x, y);
        mdl.drive(1'b0, 32'h0000_0000, 64'h0, 64'h0);
        chk(result, {pf, il, 1'b1});
    endtask : go
    task automatic close_out();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        chk({pst, tl, gl, result}, {13'h0004, 3'h6, 3'h3, 3'h0});
        go(7, 1'b1, 13'h0005, 64'h0, 64'h0, 1'b0, 1'b0);
        chk(tl, 3'h5);
        go(7, 1'b1, 13'h0009, 64'h0, 64'h0, 1'b0, 1'b0);
        chk(tl, 3'h6);
        go(5, 1'b1, 13'h1FF8, 64'h0, 64'h0, 1'b0, 1'b0);
        chk(tba, 64'hFFFF_FFFF_FFFF_8000);
        go(16, 1'b1, 13'h0001, 64'h0, 64'h0, 1'b0, 1'b0);
        chk(gl, 3'h1);
        for (int c = 5; c < 17; c++) begin
            if (c != 15) begin
                go(c, 1'b0, 13'h001F, a, b, 1'b0, 1'b0);
                case (c)
                    5: chk(tba, {v[63:15], 15'h0000});
                    6: chk(pst, v[PST_W-1:0]);
                    7: chk(tl, 3'h6);
                    8: chk(pil, v[PIL_W-1:0]);
                    9: chk(cwp, v[WIN_W-1:0]);
                    10: chk(csv, v[WIN_W-1:0]);
                    11: chk(crs, v[WIN_W-1:0]);
                    12: chk(cln, v[WIN_W-1:0]);
                    13: chk(oth, v[WIN_W-1:0]);
                    14: chk(wst, v[WSTATE_W-1:0]);
                    default: chk(gl, 3'h3);
                endcase
            end
        end
        for (int c = 4; c < 32; c++) begin
            if (c == 4 || c == 15 || c > 16) begin
                snap = glob;
                go(c, 1'b0, 13'h001F, a, b, 1'b0, 1'b1);
                chk(glob, snap);
            end
        end
        snap = glob;
        go(8, 1'b0, 13'h0025, a, b, 1'b0, 1'b1);
        chk(glob, snap);
        go(8, 1'b1, 13'h0025, 64'h0, 64'h0, 1'b0, 1'b0);
        chk(pil, 4'h5);
        go(7, 1'b1, 13'h0002, 64'h0, 64'h0, 1'b0, 1'b0);
        for (int c = 0; c < 4; c++) begin
            go(c, 1'b0, 13'h001F, a, b, 1'b0, 1'b0);
        end
        chk({tpc, tnpc}, {v, v});
        chk({tst, ttc}, {v[TST_W-1:0], v[TT_W-1:0]});
        snap = glob;
        mdl.drive(1'b1, mk(7, 1'b1, 13'h0001), 64'h0, 64'h0);
        mdl.drive(1'b1, mk(0, 1'b1, 13'h00AB), 64'h0, 64'h0);
        chk(result, 3'h1);
        mdl.drive(1'b0, 32'h0000_0000, 64'h0, 64'h0);
        chk(result, 3'h1);
        chk(tpc, 64'h0000_0000_0000_00AB);
        chk(glob, snap);
        go(7, 1'b1, 13'h0002, 64'h0, 64'h0, 1'b0, 1'b0);
        chk(tpc, v);
        go(7, 1'b1, 13'h0000, 64'h0, 64'h0, 1'b0, 1'b0);
        for (int c = 0; c < 4; c++) begin
            go(c, 1'b1, 13'h0005, 64'h0, 64'h0, 1'b0, 1'b1);
        end
        go(6, 1'b1, 13'h0000, 64'h0, 64'h0, 1'b0, 1'b0);
        chk(pst, 13'h0000);
        go(0, 1'b1, 13'h0005, 64'h0, 64'h0, 1'b1, 1'b0);
        snap = glob;
        go(16, 1'b1, 13'h0001, 64'h0, 64'h0, 1'b1, 1'b0);
        chk(glob, snap);
        close_out();
    end
endmodule : pwr_unit_tb
